// ---- dv/can_mailbox_filter_tb.sv ----
// Purpose: Self-checking bench for the mailbox and filter window
// Assumes: Whole run counts as controller init mode
// Notes: Random data from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_filter_tb;
  import can_regs_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] empty = 2'b00;
  logic [7:0] ctl [0:1] = '{default: 8'h00};
  logic rx_load = 1'b0;
  logic [7:0] rx_idx = 8'h00;
  logic [7:0] rx_b [0:13] = '{default: 8'h00};
  wire logic [2:0] page;
  wire logic [3:0] addr;
  wire logic wr;
  wire logic rd;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic [11:0] scale;
  wire logic [5:0] act;
  wire logic [11:0] lmode;
  wire logic [7:0] pulse;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h00000bc8;
  logic [7:0] v, got, m0, m1, ie;
  logic [7:0] cv [0:2];
  logic [7:0] bk [0:15];
  logic [7:0] mb [0:1][0:15];
  logic [7:0] rxe [0:13];
  logic [5:0] ea;
  logic [11:0] es;
  always #50 clock_i = ~clock_i;
  cpu_window_model i_cpu_window_model (.clock_i(clock_i), .rdata_i(rdata), .page_o(page), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  can_mailbox_filter i_can_mailbox_filter (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .window_page_select_i(page), .win_addr_i(addr), .win_wr_i(wr), .win_rd_i(rd), .win_wdata_i(wdata),
    .tx_mailbox_empty_flag_i(empty), .tx_mailbox_ctrl_status_i(ctl), .rx_load_i(rx_load),
    .rx_match_index_i(rx_idx), .rx_bytes_i(rx_b), .win_rdata_o(rdata), .filter_scale_field_o(scale),
    .filter_activation_bit_o(act), .filter_list_mode_o(lmode), .cfg_write_pulse_o(pulse));
  // ==========================================
  // Helpers
  function automatic logic [7:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic rnd(output logic [7:0] r);
    r = xorshift();
  endtask
  function automatic logic [7:0] mbmask(input int a);
    if (a == int'(OFS_ID0))
      return ID0_MASK;
    if (a == int'(OFS_LEN))
      return LEN_MASK;
    return 8'hff;
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [2:0] p, input logic [3:0] a, input logic [7:0] e);
    i_cpu_window_model.rd(p, a, got);
    chk({4'h0, got}, {4'h0, e});
  endtask
  task automatic reset_chk();
    for (int i = 0; i < 3; i++)
      rc(PAGE_CFG, OFS_CFG01 + 4'(i), CFG_RST);
    rc(PAGE_CFG, OFS_MODE0, MODE_RST);
    rc(PAGE_RX, OFS_CTRL, MATCH_RST);
    chk({6'h00, act}, 12'h000);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    final_report();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reset_chk();
    repeat (8)
    begin
      for (int i = 0; i < 3; i++)
      begin
        rnd(v);
        cv[i] = v;
        i_cpu_window_model.wr(PAGE_CFG, OFS_CFG01 + 4'(i), v);
      end
      rnd(m0);
      i_cpu_window_model.wr(PAGE_CFG, OFS_MODE0, m0);
      rnd(m1);
      i_cpu_window_model.wr(PAGE_CFG, OFS_MODE1, m1);
      #1;
      chk({4'h0, pulse}, {4'h0, 8'(1 << OFS_MODE1[2:0])});
      repeat (2) @(posedge clock_i);
      #1;
      for (int k = 0; k < 3; k++)
      begin
        ea[2*k] = cv[k][0];
        ea[2*k+1] = cv[k][4];
        es[4*k +: 2] = cv[k][2:1];
        es[4*k+2 +: 2] = cv[k][6:5];
      end
      chk({6'h00, act}, {6'h00, ea});
      chk(scale, es);
      chk(lmode, {m1[3:0], m0});
      chk({4'h0, pulse}, 12'h000);
      for (int i = 0; i < 3; i++)
        rc(PAGE_CFG, OFS_CFG01 + 4'(i), cv[i] & CFG_MASK);
      rc(PAGE_CFG, OFS_MODE0, m0);
      rc(PAGE_CFG, OFS_MODE1, m1 & MODE1_MASK);
    end
    i_cpu_window_model.wr(PAGE_CFG, OFS_CFG01, 8'h00);
    for (int a = 0; a < 16; a++)
    begin
      rnd(v);
      bk[a] = v;
      i_cpu_window_model.wr(PAGE_FLT01, 4'(a), v);
    end
    i_cpu_window_model.wr(PAGE_CFG, OFS_CFG01, 8'h01);
    for (int a = 0; a < 16; a++)
    begin
      rnd(v);
      if (a > 7)
        bk[a] = v;
      i_cpu_window_model.wr(PAGE_FLT01, 4'(a), v);
    end
    for (int a = 0; a < 16; a++)
      rc(PAGE_FLT01, 4'(a), bk[a]);
    @(posedge clock_i);
    empty <= 2'b11;
    rnd(v);
    ctl[0] <= v;
    rnd(v);
    ctl[1] <= v;
    @(posedge clock_i);
    for (int pg = 0; pg < 2; pg++)
    begin
      rc(3'(pg), OFS_CTRL, ctl[pg]);
      for (int a = 1; a < 14; a++)
      begin
        rnd(v);
        mb[pg][a] = v & mbmask(a);
        i_cpu_window_model.wr(3'(pg), 4'(a), v);
      end
      for (int a = 1; a < 14; a++)
        rc(3'(pg), 4'(a), mb[pg][a]);
    end
    @(posedge clock_i);
    empty <= 2'b00;
    for (int pg = 0; pg < 2; pg++)
    begin
      for (int a = 1; a < 14; a++)
      begin
        rnd(v);
        i_cpu_window_model.wr(3'(pg), 4'(a), v);
      end
      for (int a = 1; a < 14; a++)
        rc(3'(pg), 4'(a), mb[pg][a]);
    end
    @(posedge clock_i);
    for (int a = 0; a < 14; a++)
    begin
      rnd(v);
      rxe[a] = v & mbmask(a + 1);
      rx_b[a] <= rxe[a];
    end
    rnd(ie);
    rx_idx <= ie;
    rx_load <= 1'b1;
    @(posedge clock_i);
    rx_load <= 1'b0;
    for (int a = 0; a < 15; a++)
    begin
      rnd(v);
      i_cpu_window_model.wr(PAGE_RX, 4'(a), v);
    end
    rc(PAGE_RX, OFS_CTRL, ie);
    for (int a = 1; a < 15; a++)
      rc(PAGE_RX, 4'(a), rxe[a-1]);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reset_chk();
    final_report();
  end
endmodule
`default_nettype wire

// ---- dv/cpu_window_model.sv ----
// Purpose: CPU side of the paged register window
// Assumes: One access at a time, issued after a rising edge
// Notes: Read data is taken just after the edge that registers it
`timescale 1ns/1ps
`default_nettype none
module cpu_window_model
(
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output var logic [2:0] page_o,
  output var logic [3:0] addr_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic [7:0] wdata_o
);
  import can_regs_pkg::*;
  initial
  begin
    page_o = 3'h0;
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // ==========================================
  // Window accesses
  task automatic wr(input logic [2:0] p, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    if (p <= PAGE_TX1 && a == OFS_LEN)
      d[7] = 1'b0;
    page_o <= p;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    page_o <= p;
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- hdl/can_mailbox_filter.sv ----
// Purpose: Paged register window for mailboxes and filter configuration
// Assumes: Window strobes synchronous to clock_i
// Notes: Filter bank words are stored here; matching lives outside
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_filter
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] window_page_select_i,
  input wire logic [can_regs_pkg::WIN_AW-1:0] win_addr_i,
  input wire logic win_wr_i,
  input wire logic win_rd_i,
  input wire logic [7:0] win_wdata_i,
  input wire logic [1:0] tx_mailbox_empty_flag_i,
  input wire logic [7:0] tx_mailbox_ctrl_status_i [0:1],
  input wire logic rx_load_i,
  input wire logic [7:0] rx_match_index_i,
  input wire logic [7:0] rx_bytes_i [0:13],
  output logic [7:0] win_rdata_o,
  output logic [11:0] filter_scale_field_o,
  output logic [5:0] filter_activation_bit_o,
  output logic [11:0] filter_list_mode_o,
  output logic [7:0] cfg_write_pulse_o
);
  import can_regs_pkg::*;
  typedef struct packed
  {
    logic [7:0] rdata;
    logic [7:0] match_index_field;
    logic [11:0] scale;
    logic [5:0] act;
    logic [11:0] lmode;
    logic [7:0] cfgw;
    logic [5:0][7:0][7:0] bank;
  } top_state_t;
  top_state_t cur, next_cur;
  logic [7:0] tx0_b [0:13];
  logic [7:0] tx1_b [0:13];
  logic [7:0] rx_b [0:13];
  logic [7:0] mode0, mode1;
  logic [7:0] cfg [0:2];
  logic tx0_wr, tx1_wr, cfg_wr, page_is_flt;
  logic [2:0] pair_sel;
  logic [2:0] fidx;
  logic [3:0] ridx;
  logic [7:0] tx_sel_b [0:13];
  // ==========================================================
  // Write steering
  // ==========================================================
  always_comb
  begin
    // only an empty transmit mailbox takes writes; the receive one never
    tx0_wr = win_wr_i && window_page_select_i == PAGE_TX0 && tx_mailbox_empty_flag_i[0] && win_addr_i != OFS_CTRL;
    tx1_wr = win_wr_i && window_page_select_i == PAGE_TX1 && tx_mailbox_empty_flag_i[1] && win_addr_i != OFS_CTRL;
    cfg_wr = win_wr_i && window_page_select_i == PAGE_CFG;
    page_is_flt = window_page_select_i >= PAGE_FLT01 && window_page_select_i <= PAGE_FLT45;
    pair_sel = window_page_select_i - PAGE_FLT01;
    fidx = 3'(pair_sel * 2) + {2'h0, win_addr_i[3]};
    ridx = {1'b0, win_addr_i[2:0]};
  end
  mailbox_store u_tx0
  (
    .clock_i(clock_i),
    .wr_i(tx0_wr),
    .addr_i(win_addr_i),
    .wdata_i(win_wdata_i),
    .load_i(1'b0),
    .load_bytes_i(rx_bytes_i),
    .bytes_o(tx0_b)
  );
  mailbox_store u_tx1
  (
    .clock_i(clock_i),
    .wr_i(tx1_wr),
    .addr_i(win_addr_i),
    .wdata_i(win_wdata_i),
    .load_i(1'b0),
    .load_bytes_i(rx_bytes_i),
    .bytes_o(tx1_b)
  );
  mailbox_store u_rx
  (
    .clock_i(clock_i),
    .wr_i(1'b0),
    .addr_i(win_addr_i),
    .wdata_i(win_wdata_i),
    .load_i(rx_load_i),
    .load_bytes_i(rx_bytes_i),
    .bytes_o(rx_b)
  );
  filter_config u_cfg
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(cfg_wr),
    .addr_i(win_addr_i),
    .wdata_i(win_wdata_i),
    .mode0_o(mode0),
    .mode1_o(mode1),
    .cfg_o(cfg)
  );
  // ==========================================================
  // Next state and read mux
  // ==========================================================
  always_comb
  begin
    next_cur = cur;
    next_cur.cfgw = 8'h00;
    for (int i = 0; i < 14; i++)
    begin
      tx_sel_b[i] = window_page_select_i == PAGE_TX1 ? tx1_b[i] : tx0_b[i];
    end
    if (rx_load_i)
    begin
      next_cur.match_index_field = rx_match_index_i;
    end
    for (int f = 0; f < NUM_FILTERS; f++)
    begin
      next_cur.act[f] = cfg[f/2][(f%2)*4];
      next_cur.scale[f*2 +: 2] = cfg[f/2][(f%2)*4+1 +: 2];
    end
    next_cur.lmode = {mode1[3:0], mode0};
    // bank words change only while the filter is inactive
    if (win_wr_i && page_is_flt && !cur.act[fidx])
    begin
      next_cur.bank[fidx][ridx[2:0]] = win_wdata_i;
    end
    if (cfg_wr)
    begin
      next_cur.cfgw[win_addr_i[2:0]] = 1'b1;
    end
    next_cur.rdata = 8'h00;
    if (win_rd_i)
    begin
      case (window_page_select_i)
        PAGE_TX0, PAGE_TX1:
        begin
          if (win_addr_i == OFS_CTRL)
          begin
            next_cur.rdata = tx_mailbox_ctrl_status_i[window_page_select_i[0]];
          end
          else if (win_addr_i <= 4'he)
          begin
            next_cur.rdata = tx_sel_b[win_addr_i - 4'h1];
          end
        end
        PAGE_RX:
        begin
          if (win_addr_i == OFS_CTRL)
          begin
            next_cur.rdata = cur.match_index_field;
          end
          else if (win_addr_i <= 4'he)
          begin
            next_cur.rdata = rx_b[win_addr_i - 4'h1];
          end
        end
        PAGE_CFG:
        begin
          case (win_addr_i)
            OFS_MODE0: next_cur.rdata = mode0;
            OFS_MODE1: next_cur.rdata = mode1;
            OFS_CFG01: next_cur.rdata = cfg[0];
            OFS_CFG23: next_cur.rdata = cfg[1];
            OFS_CFG45: next_cur.rdata = cfg[2];
            default: next_cur.rdata = 8'h00;
          endcase
        end
        default:
        begin
          if (page_is_flt)
          begin
            next_cur.rdata = cur.bank[fidx][ridx[2:0]];
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cur.rdata <= 8'h00;
      cur.match_index_field <= MATCH_RST;
      cur.scale <= 12'h000;
      cur.act <= 6'h00;
      cur.lmode <= 12'h000;
      cur.cfgw <= 8'h00;
      cur.bank <= cur.bank;
    end
    else
    begin
      cur <= next_cur;
    end
  end
  assign win_rdata_o = cur.rdata;
  assign filter_scale_field_o = cur.scale;
  assign filter_activation_bit_o = cur.act;
  assign filter_list_mode_o = cur.lmode;
  assign cfg_write_pulse_o = cur.cfgw;
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  rx_index_ro_a: assert property (win_wr_i && window_page_select_i == PAGE_RX && !rx_load_i |=>
    $stable(cur.match_index_field)) else $error("match index changed on write");
  match_load_a: assert property (rx_load_i |=> cur.match_index_field == $past(rx_match_index_i))
    else $error("match index not loaded");
  // Offset taken from the write edge, the window may move on at once
  tx_protect_a: assert property (win_wr_i && window_page_select_i == PAGE_TX0
    && !tx_mailbox_empty_flag_i[0] && win_addr_i != OFS_CTRL && win_addr_i != 4'hf |=>
    tx0_b[$past(win_addr_i) - 4'h1] == $past(tx0_b[win_addr_i - 4'h1]))
    else $error("full mailbox written");
  tx1_protect_a: assert property (win_wr_i && window_page_select_i == PAGE_TX1
    && !tx_mailbox_empty_flag_i[1] && win_addr_i != OFS_CTRL && win_addr_i != 4'hf |=>
    tx1_b[$past(win_addr_i) - 4'h1] == $past(tx1_b[win_addr_i - 4'h1]))
    else $error("full mailbox written");
  rx_store_ro_a: assert property (win_wr_i && window_page_select_i == PAGE_RX
    && !rx_load_i && win_addr_i != OFS_CTRL && win_addr_i != 4'hf |=>
    rx_b[$past(win_addr_i) - 4'h1] == $past(rx_b[win_addr_i - 4'h1]))
    else $error("receive mailbox written");
  rx_read_a: assert property (win_rd_i && window_page_select_i == PAGE_RX
    && win_addr_i != OFS_CTRL && win_addr_i != 4'hf |=>
    win_rdata_o == $past(rx_b[win_addr_i - 4'h1]))
    else $error("receive byte not shown");
  id0_rsv_a: assert property (win_rd_i && window_page_select_i == PAGE_TX0 && win_addr_i == OFS_ID0 |=>
    win_rdata_o[7] == 1'b0) else $error("id byte0 bit7 set");
  len_rsv_a: assert property (win_rd_i && window_page_select_i == PAGE_TX1 && win_addr_i == OFS_LEN |=>
    win_rdata_o[7:4] == 4'h0) else $error("length upper bits set");
  cfg_rsv_a: assert property (win_rd_i && window_page_select_i == PAGE_CFG && win_addr_i == OFS_CFG01 |=>
    win_rdata_o[7] == 1'b0 && win_rdata_o[3] == 1'b0) else $error("config reserved set");
  // Config outputs lag a config write by two edges
  act_track_a: assert property (cfg_wr && win_addr_i == OFS_CFG23 |=> ##1
    filter_activation_bit_o[3] == $past(win_wdata_i[4], 2)) else $error("activation not tracked");
  act_even_a: assert property (cfg_wr && win_addr_i == OFS_CFG01 |=> ##1
    filter_activation_bit_o[0] == $past(win_wdata_i[0], 2)) else $error("activation not tracked");
  scale_even_a: assert property (cfg_wr && win_addr_i == OFS_CFG01 |=> ##1
    filter_scale_field_o[1:0] == $past(win_wdata_i[2:1], 2)) else $error("scale not tracked");
  scale_odd_a: assert property (cfg_wr && win_addr_i == OFS_CFG45 |=> ##1
    filter_scale_field_o[11:10] == $past(win_wdata_i[6:5], 2)) else $error("scale not tracked");
  mode_track_a: assert property (cfg_wr && win_addr_i == OFS_MODE0 |=> ##1
    filter_list_mode_o[7:0] == $past(win_wdata_i, 2)) else $error("mode not tracked");
  mode_high_a: assert property (cfg_wr && win_addr_i == OFS_MODE1 |=> ##1
    filter_list_mode_o[11:8] == $past(win_wdata_i[3:0], 2)) else $error("upper mode not tracked");
  // Control and status of the selected transmit mailbox sits at offset 0
  ctrl_map_a: assert property (win_rd_i && window_page_select_i == PAGE_TX0 && win_addr_i == OFS_CTRL |=>
    win_rdata_o == $past(tx_mailbox_ctrl_status_i[0])) else $error("ctrl status not mapped");
  ctrl_map1_a: assert property (win_rd_i && window_page_select_i == PAGE_TX1 && win_addr_i == OFS_CTRL |=>
    win_rdata_o == $past(tx_mailbox_ctrl_status_i[1])) else $error("ctrl status not mapped");
  // Bank words move only through an accepted write
  bank_lock_a: assert property (win_wr_i && page_is_flt && cur.act[fidx] |=> $stable(cur.bank))
    else $error("active filter bank written");
  bank_store_a: assert property (win_wr_i && page_is_flt && !cur.act[fidx] |=>
    cur.bank[$past(fidx)][$past(ridx[2:0])] == $past(win_wdata_i))
    else $error("bank word not stored");
  rdata_idle_a: assert property (!win_rd_i |=> win_rdata_o == 8'h00)
    else $error("read data without read");
  pulse_a: assert property (cfg_wr |=> cfg_write_pulse_o == (8'h01 << $past(win_addr_i[2:0])))
    else $error("config pulse wrong");
  pulse_idle_a: assert property (!cfg_wr |=> cfg_write_pulse_o == 8'h00)
    else $error("config pulse without write");
  reset_zero_a: assert property (@(posedge clock_i) $fell(sys_rst_i) |->
    filter_activation_bit_o == 6'h00 && cur.match_index_field == MATCH_RST) else $error("reset value");
  // ==========================================================
  // Cover points
  // ==========================================================
  cover_tx_wr_c: cover property (tx0_wr);
  cover_rx_rd_c: cover property (win_rd_i && window_page_select_i == PAGE_RX);
  cover_bank_wr_c: cover property (win_wr_i && page_is_flt);
  cover_cfg_wr_c: cover property (cfg_wr);
  cover_rx_load_c: cover property (rx_load_i);
endmodule
`default_nettype wire

// ---- hdl/can_regs_pkg.sv ----
// Purpose: Constants for the CAN mailbox and filter register window
// Assumes: Byte-wide paged window at 70h..7Fh
// Notes: Scale encoding and window port are local choices
package can_regs_pkg;
  localparam int unsigned WIN_AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LEN = 4'h1;
  localparam logic [3:0] OFS_ID0 = 4'h2;
  localparam logic [3:0] OFS_ID1 = 4'h3;
  localparam logic [3:0] OFS_ID2 = 4'h4;
  localparam logic [3:0] OFS_ID3 = 4'h5;
  localparam logic [3:0] OFS_DATA0 = 4'h6;
  localparam logic [3:0] OFS_MODE0 = 4'h8;
  localparam logic [3:0] OFS_MODE1 = 4'h9;
  localparam logic [3:0] OFS_CFG01 = 4'ha;
  localparam logic [3:0] OFS_CFG23 = 4'hb;
  localparam logic [3:0] OFS_CFG45 = 4'hc;
  localparam logic [2:0] PAGE_TX0 = 3'h0;
  localparam logic [2:0] PAGE_TX1 = 3'h1;
  localparam logic [2:0] PAGE_FLT01 = 3'h2;
  localparam logic [2:0] PAGE_FLT45 = 3'h4;
  localparam logic [2:0] PAGE_CFG = 3'h6;
  localparam logic [2:0] PAGE_RX = 3'h7;
  localparam int unsigned ID0_EXT_BIT = 6;
  localparam int unsigned ID0_RTR_BIT = 5;
  localparam logic [7:0] ID0_MASK = 8'h7f;
  localparam logic [7:0] LEN_MASK = 8'h0f;
  localparam logic [7:0] CFG_MASK = 8'h77;
  localparam logic [7:0] MODE1_MASK = 8'h0f;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam int unsigned NUM_FILTERS = 6;
  localparam int unsigned NUM_DATA = 8;
  // Scale: 0 = four 8-bit, 1 = two 16-bit, 2 = 32-bit, 3 = reserved (no match)
  typedef enum logic [1:0] {SCALE_8 = 2'h0, SCALE_16 = 2'h1, SCALE_32 = 2'h2, SCALE_RSV = 2'h3} scale_t;
endpackage

// ---- hdl/filter_config.sv ----
// Purpose: Filter configuration and mode registers
// Assumes: Software writes only in init mode
// Notes: Reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module filter_config
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [can_regs_pkg::WIN_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] mode0_o,
  output logic [7:0] mode1_o,
  output logic [7:0] cfg_o [0:2]
);
  import can_regs_pkg::*;
  typedef struct packed { logic [7:0] m0; logic [7:0] m1; logic [2:0][7:0] c; } fc_state_t;
  fc_state_t cur, next_cur;
  always_comb
  begin
    next_cur = cur;
    if (wr_i)
    begin
      case (addr_i)
        OFS_MODE0: next_cur.m0 = wdata_i;
        OFS_MODE1: next_cur.m1 = wdata_i & MODE1_MASK;
        OFS_CFG01: next_cur.c[0] = wdata_i & CFG_MASK;
        OFS_CFG23: next_cur.c[1] = wdata_i & CFG_MASK;
        OFS_CFG45: next_cur.c[2] = wdata_i & CFG_MASK;
        default: next_cur = cur;
      endcase
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cur <= '{m0: MODE_RST, m1: MODE_RST, c: {CFG_RST, CFG_RST, CFG_RST}};
    end
    else
    begin
      cur <= next_cur;
    end
  end
  assign mode0_o = cur.m0;
  assign mode1_o = cur.m1;
  assign cfg_o[0] = cur.c[0];
  assign cfg_o[1] = cur.c[1];
  assign cfg_o[2] = cur.c[2];
endmodule
`default_nettype wire

// ---- hdl/mailbox_store.sv ----
// Purpose: One mailbox: identifier, length and payload bytes
// Assumes: Writes gated by caller
// Notes: Reserved bits forced on write
`timescale 1ns/1ps
`default_nettype none
module mailbox_store
(
  input wire logic clock_i,
  input wire logic wr_i,
  input wire logic [can_regs_pkg::WIN_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic load_i,
  input wire logic [7:0] load_bytes_i [0:13],
  output logic [7:0] bytes_o [0:13]
);
  import can_regs_pkg::*;
  typedef struct packed { logic [13:0][7:0] b; } mb_state_t;
  mb_state_t cur, next_cur;
  logic [7:0] wmask;
  logic [3:0] idx;
  always_comb
  begin
    next_cur = cur;
    idx = addr_i - 4'h1;
    wmask = 8'hff;
    if (addr_i == OFS_ID0)
    begin
      wmask = ID0_MASK;
    end
    if (addr_i == OFS_LEN)
    begin
      wmask = LEN_MASK;
    end
    if (load_i)
    begin
      for (int i = 0; i < 14; i++)
      begin
        next_cur.b[i] = load_bytes_i[i];
      end
    end
    else if (wr_i && addr_i != OFS_CTRL && addr_i != 4'hf)
    begin
      next_cur.b[idx] = wdata_i & wmask;
    end
  end
  always_ff @(posedge clock_i)
  begin
    cur <= next_cur;
  end
  genvar g;
  generate
    for (g = 0; g < 14; g++)
    begin : g_out
      assign bytes_o[g] = cur.b[g];
    end
  endgenerate
endmodule
`default_nettype wire
